/* File: verilog/crs_pkg.sv */
/*
 clock and reset sequencer package: register offsets, reset values, field positions, cycle counts.
 assumes a byte-wide register port and one 200 MHz reference clock.
*/
package crs_pkg;
  localparam logic [7:0] CRS_ADDR_MAIN_CTL = 8'h38;
  localparam logic [7:0] CRS_ADDR_TRIM_HI = 8'h39;
  localparam logic [7:0] CRS_ADDR_SYS_INT = 8'h3a;
  localparam logic [7:0] CRS_ADDR_PRESC = 8'h3e;
  localparam logic [7:0] CRS_ADDR_OSC_SW = 8'h3f;

  localparam logic [7:0] CRS_RST_MAIN_CTL = 8'h00;
  localparam logic [7:0] CRS_RST_TRIM_HI = 8'hff;
  localparam logic [7:0] CRS_RST_PRESC = 8'h03;
  localparam logic [1:0] CRS_RST_TRIM_LO = 2'h0;

  // field positions
  localparam int CRS_BIT_SLOW = 0;
  localparam int CRS_BIT_CLKOUT = 1;
  localparam int CRS_POS_TRIM_LO = 5;
  localparam int CRS_POS_PRESC = 5;
  localparam int CRS_BIT_OSC_SEL = 0;
  localparam int CRS_BIT_FAST_RDY = 2;
  localparam int CRS_BIT_WAKE_RDY = 3;

  localparam int CRS_SLOW_DIV = 32;
  localparam int CRS_DELAY_FAST = 512;
  localparam int CRS_DELAY_WAKE = 256;
  localparam int CRS_FETCH_CYCLES = 2;
  localparam int CRS_WAKE_SETTLE = 3;
  localparam int CRS_FAST_SETTLE = 8;
  localparam logic [15:0] CRS_RESET_VECTOR = 16'hfffe;

  typedef enum logic [2:0] {
    CRS_ST_ACTIVE = 3'b001,
    CRS_ST_DELAY = 3'b010,
    CRS_ST_RUN = 3'b100
  } crs_phase_e;

  typedef struct packed {
    logic pin_low;
    logic low_voltage_detector;
    logic wdg;
    logic illegal;
  } crs_src_s;

  typedef struct packed {
    logic [7:0] main_ctl;
    logic [7:0] trim_hi;
    logic [1:0] trim_lo;
    logic [2:0] presc;
    logic [1:0] vthr;
    logic osc_sel;
    logic wake_rdy;
    logic fast_rdy;
    logic [3:0] sw_cnt;
    logic sw_busy;
    logic [4:0] slow_cnt;
    logic [3:0] rc_cnt;
    logic use_wake;
    logic halt_wake;
    crs_phase_e phase;
    logic [9:0] dly_cnt;
    logic [1:0] fetch_cnt;
    logic fetch;
    logic [7:0] rdata;
    logic rst_s1;
    logic rst_s2;
  } crs_state_s;
endpackage : crs_pkg

/* File: verilog/crs_sequencer.sv */
/*
 clock and reset sequencer: clock control registers, oscillator switching, cpu enables, reset phases.
 assumes oscillators are modelled as enables on ref_clk and reset sources are synchronous except the pin.
*/
// Local design decision: the strobed register port.
// Notes on behaviour
// - clock output pin carries main clock when enable bit set, held low while a switch is busy, released when bit clear.
// - slow mode bit selects cpu clock undivided or divided by 32.
// - trim is 10 bits: high byte register plus bits 6:5 of integrity register.
// - trim 00h is fastest rc frequency, ffh slowest.
// - prescaler codes 1..4 divide rc by 2,4,8,16; others pass undivided.
// - wake oscillator ready flag is hardware owned, set after its settling wait.
// - fast oscillator ready flag is hardware owned, set after its settling wait.
// - oscillator select 0 picks rc, 1 (reset default) picks wake oscillator.
// - pin, low voltage, watchdog and illegal opcode all start a reset.
// - every source drives reset pin low throughout the delay phase.
// - reset runs active phase, fixed delay, then vector fetch.
// - delay is 512 cycles on rc or external clock, 256 on wake oscillator.
// - delay length follows option source at power-on, source in use at other resets, prior source after halt.
// - vector fetch lasts two cycles at fffeh-ffffh.
// - reset pin is input plus open-drain output with weak pull-up.
// - external pin reset acts asynchronously, even without a clock; here only the pin flops set at once, cpu_reset waits three ref_clk edges.
// - switch to wake oscillator waits three wake cycles before ready.
// - switch back to rc counts eight rc cycles before flags change.
// - changeover happens on new oscillator edge, then old one stops.
module crs_sequencer
  import crs_pkg::*;
#(
  parameter int DELAY_FAST = CRS_DELAY_FAST, // rc delay cycles
  parameter int DELAY_WAKE = CRS_DELAY_WAKE  // wake osc delay cycles
) (
  input wire logic ref_clk, // 200 MHz reference
  input wire logic rst, // async active high power-on reset
  input wire logic [7:0] addr, // register address
  input wire logic [7:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [7:0] rdata, // read data, cycle after rd
  input wire logic rc_tick, // one pulse per rc oscillator cycle
  input wire logic wake_tick, // one pulse per wake oscillator cycle
  input wire logic opt_wake_src, // option byte: power-on delay uses the wake osc count
  input wire logic halt_entry, // pulse: cpu enters halt
  input wire logic lvd_req, // low voltage reset request
  input wire logic wdg_req, // watchdog reset request
  input wire logic illegal_req, // illegal opcode or prebyte
  input wire logic reset_n_in, // reset pin level
  output logic reset_n_out, // reset pin drive value (always 0)
  output logic reset_n_oe, // reset pin pull-low enable
  output logic clkout_en, // clock output pin enabled
  output logic clkout, // clock output pin level
  output logic osc_en, // oscillator clock enable pulse
  output logic cpu_en, // cpu clock enable pulse
  output logic [9:0] rc_trim, // trim to rc oscillator
  output logic rc_run, // rc oscillator running
  output logic wake_run, // wake oscillator running
  output logic cpu_reset, // internal reset to cpu
  output logic vector_fetch, // cpu fetching reset vector
  output logic [15:0] vector_addr // reset vector address
);
  initial begin
    if (DELAY_FAST < 2 || DELAY_FAST > 1024 || DELAY_WAKE < 2 || DELAY_WAKE > 1024)
      $error("crs_sequencer: delay out of range");
  end

  crs_state_s s_q, s_d;
  logic pin_rst_n;
  logic pin_meta_q, pin_sync_q;
  crs_src_s src;
  logic any_req, src_tick, osc_pulse;

  function automatic logic [3:0] presc_mask(input logic [2:0] code);
    unique case (code)
      3'h1: presc_mask = 4'h1;
      3'h2: presc_mask = 4'h3;
      3'h3: presc_mask = 4'h7;
      3'h4: presc_mask = 4'hf;
      default: presc_mask = 4'h0;
    endcase
  endfunction : presc_mask

  // pin reset acts asynchronously
  // own pull-down masked, else the sequence would hold itself in reset forever
  assign pin_rst_n = reset_n_in || reset_n_oe;
  always_ff @(posedge ref_clk or negedge pin_rst_n or posedge rst) begin
    if (rst || !pin_rst_n) begin
      pin_meta_q <= 1'b1;
      pin_sync_q <= 1'b1;
    end else begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= pin_meta_q;
    end
  end

  assign src.pin_low = pin_sync_q;
  assign src.low_voltage_detector = lvd_req;
  assign src.wdg = wdg_req;
  assign src.illegal = illegal_req;
  assign any_req = |src;

  // active source ticks once the switch is complete
  assign src_tick = s_q.use_wake ? wake_tick : rc_tick;
  assign osc_pulse = src_tick && (s_q.use_wake || ((s_q.rc_cnt & presc_mask(s_q.presc)) == 4'h0));

  always_comb begin
    s_d = s_q;
    s_d.rdata = 8'h00;
    s_d.rst_s1 = any_req;
    s_d.rst_s2 = s_q.rst_s1;
    if (rd) begin
      unique case (addr)
        CRS_ADDR_MAIN_CTL: s_d.rdata = s_q.main_ctl;
        CRS_ADDR_TRIM_HI: s_d.rdata = s_q.trim_hi;
        CRS_ADDR_SYS_INT: s_d.rdata = {1'b0, s_q.trim_lo, 5'h00};
        CRS_ADDR_PRESC: s_d.rdata = {s_q.presc, 3'h0, s_q.vthr};
        CRS_ADDR_OSC_SW: s_d.rdata = {4'h0, s_q.wake_rdy, s_q.fast_rdy, 1'b0, s_q.osc_sel};
        default: s_d.rdata = 8'h00;
      endcase
    end
    if (wr) begin
      unique case (addr)
        CRS_ADDR_MAIN_CTL: s_d.main_ctl = {6'h00, wdata[CRS_BIT_CLKOUT], wdata[CRS_BIT_SLOW]};
        CRS_ADDR_TRIM_HI: s_d.trim_hi = wdata;
        CRS_ADDR_SYS_INT: s_d.trim_lo = wdata[CRS_POS_TRIM_LO +: 2];
        CRS_ADDR_PRESC: begin
          s_d.presc = wdata[CRS_POS_PRESC +: 3];
          s_d.vthr = wdata[1:0];
        end
        CRS_ADDR_OSC_SW: begin
          if (wdata[CRS_BIT_OSC_SEL] != s_q.osc_sel) begin
            s_d.osc_sel = wdata[CRS_BIT_OSC_SEL];
            s_d.sw_busy = 1'b1;
            s_d.sw_cnt = 4'h0;
            if (wdata[CRS_BIT_OSC_SEL]) s_d.fast_rdy = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (s_q.sw_busy) begin
      if (s_q.osc_sel) begin
        if (wake_tick) begin
          s_d.sw_cnt = s_q.sw_cnt + 4'h1;
          if (s_q.sw_cnt == 4'(CRS_WAKE_SETTLE - 1)) begin
            s_d.wake_rdy = 1'b1;
            s_d.use_wake = 1'b1;
            s_d.sw_busy = 1'b0;
          end
        end
      end else if (rc_tick) begin
        // eight rc cycles on a 4-bit counter
        s_d.sw_cnt = s_q.sw_cnt + 4'h1;
        if (s_q.sw_cnt == 4'(CRS_FAST_SETTLE - 1)) begin
          s_d.wake_rdy = 1'b0;
          s_d.fast_rdy = 1'b1;
          s_d.use_wake = 1'b0;
          s_d.sw_busy = 1'b0;
        end
      end
    end
    if (rc_tick) s_d.rc_cnt = s_q.rc_cnt + 4'h1;
    // divide by 32 in slow mode
    if (osc_pulse) s_d.slow_cnt = s_q.slow_cnt + 5'h01;
    // remember source in use at halt entry
    if (halt_entry) s_d.halt_wake = s_q.use_wake;
    s_d.fetch = 1'b0;
    unique case (s_q.phase)
      CRS_ST_ACTIVE: begin
        if (!s_q.rst_s2) begin
          s_d.phase = CRS_ST_DELAY;
          s_d.dly_cnt = 10'h000;
        end
      end
      CRS_ST_DELAY: begin
        if (s_q.rst_s2) begin
          s_d.phase = CRS_ST_ACTIVE;
        end else if (cpu_en) begin
          s_d.dly_cnt = s_q.dly_cnt + 10'h001;
          if (s_q.dly_cnt == (s_q.halt_wake ? 10'(DELAY_WAKE - 1) : 10'(DELAY_FAST - 1))) begin
            s_d.phase = CRS_ST_RUN;
            s_d.fetch_cnt = 2'(CRS_FETCH_CYCLES);
          end
        end
      end
      CRS_ST_RUN: begin
        if (s_q.rst_s2) begin
          s_d.phase = CRS_ST_ACTIVE;
          s_d.halt_wake = s_q.use_wake;
        end else if (s_q.fetch_cnt != 2'h0) begin
          s_d.fetch = 1'b1;
          s_d.fetch_cnt = s_q.fetch_cnt - 2'h1;
        end
      end
      default: s_d.phase = CRS_ST_ACTIVE;
    endcase
    // control registers except oscillator select return to defaults on any reset
    if (s_q.phase != CRS_ST_RUN) begin
      s_d.main_ctl = CRS_RST_MAIN_CTL;
      s_d.trim_hi = CRS_RST_TRIM_HI;
      s_d.trim_lo = CRS_RST_TRIM_LO;
      s_d.presc = CRS_RST_PRESC[7:5];
      s_d.vthr = CRS_RST_PRESC[1:0];
    end
  end

  // option byte source latched after release
  logic opt_taken_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{main_ctl: CRS_RST_MAIN_CTL, trim_hi: CRS_RST_TRIM_HI, trim_lo: CRS_RST_TRIM_LO,
               presc: CRS_RST_PRESC[7:5], vthr: CRS_RST_PRESC[1:0], osc_sel: 1'b1, wake_rdy: 1'b1,
               fast_rdy: 1'b0, sw_cnt: 4'h0, sw_busy: 1'b0, slow_cnt: 5'h00, rc_cnt: 4'h0,
               use_wake: 1'b1, halt_wake: 1'b1, phase: CRS_ST_ACTIVE, dly_cnt: 10'h000,
               fetch_cnt: 2'h0, fetch: 1'b0, rdata: 8'h00, rst_s1: 1'b1, rst_s2: 1'b1};
      opt_taken_q <= 1'b0;
    end else begin
      s_q <= s_d;
      if (!opt_taken_q) begin
        s_q.halt_wake <= opt_wake_src;
        opt_taken_q <= 1'b1;
      end
    end
  end

  assign osc_en = osc_pulse;
  assign cpu_en = osc_pulse && (!s_q.main_ctl[CRS_BIT_SLOW] || s_q.slow_cnt == 5'(CRS_SLOW_DIV - 1));
  assign rdata = s_q.rdata;
  assign clkout_en = s_q.main_ctl[CRS_BIT_CLKOUT];
  assign clkout = clkout_en && !s_q.sw_busy && osc_pulse;
  assign rc_trim = {s_q.trim_hi, s_q.trim_lo};
  assign rc_run = !s_q.use_wake || s_q.sw_busy;
  assign wake_run = s_q.use_wake || s_q.sw_busy;
  // pin pulled low until delay ends
  assign reset_n_oe = (s_q.phase != CRS_ST_RUN);
  assign reset_n_out = 1'b0;
  // reset held through active and delay phases
  assign cpu_reset = (s_q.phase != CRS_ST_RUN);
  assign vector_fetch = s_q.fetch;
  assign vector_addr = CRS_RESET_VECTOR;

  a_delay_exit: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(s_q.phase == CRS_ST_RUN) |-> $past(s_q.phase) == CRS_ST_DELAY)
    else $error("run entered without delay");
  a_pin_low: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.phase == CRS_ST_DELAY |-> reset_n_oe)
    else $error("pin released in delay");
  sequence fetch_two;
    vector_fetch ##1 vector_fetch ##1 !vector_fetch;
  endsequence
  a_fetch_len: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(vector_fetch) |-> fetch_two)
    else $error("fetch not two cycles");
  a_restart: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.phase == CRS_ST_DELAY && s_q.rst_s2 |=> s_q.phase == CRS_ST_ACTIVE)
    else $error("request did not restart");
  a_wake_ready: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(s_q.wake_rdy) |-> s_q.osc_sel && $past(s_q.sw_cnt) == 4'h2)
    else $error("wake ready early");
  a_fast_ready: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(s_q.fast_rdy) |-> !s_q.osc_sel && $past(s_q.sw_cnt) == 4'h7)
    else $error("fast ready early");
  a_clkout_off: assert property (@(posedge ref_clk) disable iff (rst)
    !clkout_en || s_q.sw_busy |-> !clkout)
    else $error("clock out active");
  a_trim_map: assert property (@(posedge ref_clk) disable iff (rst)
    rc_trim[9:2] == s_q.trim_hi)
    else $error("trim mapping wrong");
  a_slow_div: assert property (@(posedge ref_clk) disable iff (rst)
    cpu_en && s_q.main_ctl[CRS_BIT_SLOW] |-> s_q.slow_cnt == 5'h1f)
    else $error("slow divider wrong");

  // last delay count for the source chosen at reset or before halt
  logic [9:0] dly_last;
  assign dly_last = s_q.halt_wake ? 10'(DELAY_WAKE - 1) : 10'(DELAY_FAST - 1);

  sequence req_seen;
    s_q.rst_s2;
  endsequence

  sequence back_to_active;
    s_q.phase == CRS_ST_ACTIVE;
  endsequence

  sequence delay_done;
    s_q.phase == CRS_ST_DELAY && !s_q.rst_s2 && cpu_en && s_q.dly_cnt == dly_last;
  endsequence

  sequence fetch_start;
    s_q.phase == CRS_ST_RUN && !s_q.rst_s2 && s_q.fetch_cnt == 2'(CRS_FETCH_CYCLES);
  endsequence

  a_src_start: assert property (@(posedge ref_clk) disable iff (rst)
    req_seen |=> back_to_active)
    else $error("request did not enter active phase");

  a_active_next: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.phase == CRS_ST_ACTIVE && !s_q.rst_s2 |=> s_q.phase == CRS_ST_DELAY)
    else $error("active phase did not move to delay");

  a_delay_len: assert property (@(posedge ref_clk) disable iff (rst)
    delay_done |=> s_q.phase == CRS_ST_RUN)
    else $error("delay did not end on its count");

  a_fetch_start: assert property (@(posedge ref_clk) disable iff (rst)
    fetch_start |=> vector_fetch)
    else $error("fetch did not follow delay");

  // two flops between a request and the phase logic
  a_sync_depth: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.rst_s2 == $past(any_req, 2))
    else $error("request synchroniser depth wrong");

  a_regs_default: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.phase != CRS_ST_RUN |=> s_q.main_ctl == CRS_RST_MAIN_CTL && s_q.trim_hi == CRS_RST_TRIM_HI)
    else $error("registers not held at default in reset");

  a_fast_mode: assert property (@(posedge ref_clk) disable iff (rst)
    !s_q.main_ctl[CRS_BIT_SLOW] |-> cpu_en == osc_en)
    else $error("cpu clock divided in normal mode");

  a_presc_pass: assert property (@(posedge ref_clk) disable iff (rst)
    !s_q.use_wake && (s_q.presc == 3'h0 || s_q.presc > 3'h4) |-> osc_en == rc_tick)
    else $error("undivided prescaler code divides");

  a_presc_half: assert property (@(posedge ref_clk) disable iff (rst)
    !s_q.use_wake && s_q.presc == 3'h1 && osc_en |=> !osc_en || s_q.presc != 3'h1 || s_q.use_wake)
    else $error("divide by two prescaler wrong");

  a_clkout_on: assert property (@(posedge ref_clk) disable iff (rst)
    clkout_en && !s_q.sw_busy |-> clkout == osc_en)
    else $error("clock output not following clock");

  a_old_stopped: assert property (@(posedge ref_clk) disable iff (rst)
    !s_q.sw_busy |-> rc_run != wake_run)
    else $error("old oscillator still running");

  a_wake_flag: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(s_q.wake_rdy) |-> $past(s_q.sw_busy))
    else $error("wake flag changed outside a switch");

  a_fast_flag: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(s_q.fast_rdy) |-> $past(s_q.sw_busy) || $past(wr && addr == CRS_ADDR_OSC_SW))
    else $error("fast flag changed outside a switch");

  a_pin_release: assert property (@(posedge ref_clk) disable iff (rst)
    !reset_n_oe |-> !cpu_reset && reset_n_out == 1'b0)
    else $error("pin released while cpu in reset");
endmodule : crs_sequencer

/* File: sim/crs_ext_reset.sv */
/*
 partner model: external reset circuitry and weak pull-up on the reset pin.
 assumes the sequencer pulls the pin low through reset_n_oe and never drives it high.
*/
module crs_ext_reset (
  input wire logic ref_clk, // reference clock
  input wire logic oe, // sequencer pulls pin low
  input wire logic pull_req, // bench asks for an external reset pulse
  output logic pin // resolved pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] boot_q = 3'h0;
  always @(posedge ref_clk) begin
    if (boot_q != 3'h4) begin
      boot_q <= boot_q + 3'h1;
    end
  end
  assign pin = (oe || pull_req || boot_q != 3'h4) ? 1'b0 : 1'b1;
endmodule : crs_ext_reset

/* File: sim/tb.sv */
/*
 self-checking bench for the clock and reset sequencer.
 assumes the register port answers one cycle after rd and oscillator ticks come from this bench.
*/
module tb import crs_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DF = 12;
  localparam int DW = 6;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} crs_row_s;
  // reset values, then writes; the 0x40 rows probe an unmapped place
  crs_row_s rows [11] = '{'{1'b0, 8'h38, 8'h00, 8'h00}, '{1'b0, 8'h39, 8'h00, 8'hff},
    '{1'b0, 8'h3a, 8'h00, 8'h00}, '{1'b0, 8'h3e, 8'h00, 8'h03}, '{1'b0, 8'h3f, 8'h00, 8'h09},
    '{1'b0, 8'h40, 8'h00, 8'h00}, '{1'b1, 8'h38, 8'h03, 8'h03}, '{1'b1, 8'h39, 8'h80, 8'h80},
    '{1'b1, 8'h3a, 8'h60, 8'h60}, '{1'b1, 8'h3e, 8'h03, 8'h03}, '{1'b1, 8'h40, 8'h5a, 8'h00}};
  logic ref_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rc_tick = 1'b0, wake_tick = 1'b0;
  logic opt_wake_src = 1'b1, lvd_req = 1'b0, wdg_req = 1'b0, illegal_req = 1'b0, pull_req = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
  logic reset_n_out, reset_n_oe, clkout_en, clkout, osc_en, cpu_en, rc_run, wake_run, cpu_reset, vector_fetch;
  logic pin;
  logic [9:0] rc_trim;
  logic [15:0] vector_addr;
  int n_mismatch = 0, n_checks = 0, no, nc, ex;
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    rc_tick <= 1'b1;
    wake_tick <= ~wake_tick;
  end
  crs_sequencer #(.DELAY_FAST(DF), .DELAY_WAKE(DW)) u_dut (.ref_clk(ref_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rc_tick(rc_tick), .wake_tick(wake_tick),
    .opt_wake_src(opt_wake_src), .halt_entry(1'b0), .lvd_req(lvd_req), .wdg_req(wdg_req),
    .illegal_req(illegal_req), .reset_n_in(pin), .reset_n_out(reset_n_out), .reset_n_oe(reset_n_oe),
    .clkout_en(clkout_en), .clkout(clkout), .osc_en(osc_en), .cpu_en(cpu_en), .rc_trim(rc_trim),
    .rc_run(rc_run), .wake_run(wake_run), .cpu_reset(cpu_reset), .vector_fetch(vector_fetch),
    .vector_addr(vector_addr));
  crs_ext_reset u_ext (.ref_clk(ref_clk), .oe(reset_n_oe), .pull_req(pull_req), .pin(pin));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic c, input string m);
    n_checks++;
    if (c !== 1'b1) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  task automatic count(input int cyc);
    no = 0;
    nc = 0;
    repeat (cyc) begin
      @(posedge ref_clk);
      #1;
      if (osc_en === 1'b1) no++;
      if (cpu_en === 1'b1) nc++;
    end
  endtask : count
  // follow one reset sequence to its end and the vector fetch after it
  task automatic seq(input int lo, input int hi);
    int n, i, f;
    n = 0;
    f = 0;
    for (i = 0; i < 800 && cpu_reset !== 1'b0; i++) begin
      @(posedge ref_clk);
      #1;
      if (cpu_reset === 1'b1 && cpu_en === 1'b1) n++;
      if (cpu_reset === 1'b1) chk(reset_n_oe === 1'b1, "pin released during reset");
    end
    chk(i < 800, "reset never ended");
    chk(n >= lo && n <= hi, "delay length wrong");
    for (i = 0; i < 4; i++) begin
      if (vector_fetch === 1'b1) f++;
      @(posedge ref_clk);
      #1;
    end
    chk(f == 2 && vector_addr === 16'hfffe, "vector fetch wrong");
    chk(reset_n_oe === 1'b0 && pin === 1'b1, "pin held after reset");
  endtask : seq
  task automatic poll(input logic [7:0] m, input logic [7:0] e);
    for (int i = 0; i < 60; i++) begin
      rd_reg(8'h3f, d);
      if ((d & m) !== 8'h00) break;
    end
    chk(d === e, "oscillator switch flags wrong");
  endtask : poll
  initial begin
    #(5 * 90000);
    chk(1'b0, "run timed out");
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    seq(DW, DW + 3);
    foreach (rows[i]) begin
      if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, d);
      if (d !== rows[i].e) chk(1'b0, "register read wrong"); else chk(1'b1, "");
    end
    chk(rc_trim === 10'h203, "trim value wrong");
    wr_reg(8'h38, 8'h02);
    #1 chk(clkout_en === 1'b1, "clock output not enabled");
    chk(clkout === osc_en, "clock output not following clock");
    wr_reg(8'h38, 8'h00);
    #1 chk(clkout_en === 1'b0 && clkout === 1'b0, "clock output not released");
    wr_reg(8'h3f, 8'h00);
    poll(8'h04, 8'h04);
    chk(rc_run === 1'b1 && wake_run === 1'b0, "wake oscillator not stopped");
    for (int c = 0; c < 8; c++) begin
      wr_reg(8'h3e, {c[2:0], 5'h03});
      repeat (40) @(posedge ref_clk);
      count(64);
      ex = (c >= 1 && c <= 4) ? 64 >> c : 64;
      chk(no >= ex - 1 && no <= ex + 1, "prescaler ratio wrong");
    end
    wr_reg(8'h3e, 8'h03);
    wr_reg(8'h38, 8'h01);
    count(640);
    chk(nc >= no / 32 - 1 && nc <= no / 32 + 1, "slow mode ratio wrong");
    wr_reg(8'h38, 8'h00);
    wr_reg(8'h3f, 8'h01);
    poll(8'h08, 8'h09);
    chk(wake_run === 1'b1 && rc_run === 1'b0, "fast oscillator not stopped");
    for (int s = 0; s < 4; s++) begin
      @(posedge ref_clk);
      pull_req <= (s == 0);
      lvd_req <= (s == 1);
      wdg_req <= (s == 2);
      illegal_req <= (s == 3);
      repeat (3) @(posedge ref_clk);
      pull_req <= 1'b0;
      {lvd_req, wdg_req, illegal_req} <= 3'h0;
      wr_reg(8'h39, 8'h00);
      #1 chk(cpu_reset === 1'b1, "source did not start reset");
      seq(DW, DF + 3);
      rd_reg(8'h39, d);
      chk(d === 8'hff, "trim not restored or write taken in reset");
    end
    // second request inside the delay must start it over
    @(posedge ref_clk);
    wdg_req <= 1'b1;
    @(posedge ref_clk);
    wdg_req <= 1'b0;
    repeat (6) @(posedge ref_clk);
    lvd_req <= 1'b1;
    @(posedge ref_clk);
    lvd_req <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 chk(cpu_reset === 1'b1, "reset ended despite new request");
    seq(DW - 1, DF + 3);
    @(posedge ref_clk);
    rst <= 1'b1;
    opt_wake_src <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    seq(DF, DF + 3);
    give_verdict();
  end
endmodule : tb
